// ### ssb_port.sv
// Functional notes
// - SPI moves eight bits each way at once.
// - SPI master drives the clock; slave takes it from the pin.
// - SPI setup from control bits 5:0 and status bit 6; status bit 7 is unused.
// - Runs only while enabled; disable, rewrite, re-enable to reset.
// - Select control on: select pin high resets slave logic.
// - I2C slave, 7 and 10 bit addressing, start/stop interrupts.
// - Mode field picks one of five I2C modes.
// - Enabled I2C pins set as inputs are open drain.
// - Slave transmitter overrides data pin with outgoing bits.
// - On match or data byte, drive ACK and load buffer.
// - Full or overflow blocks ACK and load; interrupt still set.
// - Buffer read clears full; overflow holds until cleared.
// - Registers visible to software; shift register hidden.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module ssb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outValid = (count_q != '0);
    assign outData = mem_q[rdPtr_q];
    assign count_d = count_q + CW'(push) - CW'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_q + PW'(push);
            rdPtr_q <= rdPtr_q + PW'(pop);
            count_q <= count_d;
            inReady <= (count_d != FULL_CNT);
        end
    end
endmodule : ssb_fifo

////////////////////////////////////////////////////////////////////////////////
module ssb_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serialClk,
    input wire logic [7:0] portControl,
    input wire logic [1:0] portStatusCfg,
    input wire logic [9:0] ownAddress,
    input wire logic [1:0] pinDirInput,
    input wire logic [7:0] writeData,
    input wire logic writeValid,
    output logic writeReady,
    input wire logic bufferRead,
    output logic [7:0] transferBuffer,
    output logic bufferFullFlag,
    output logic receiveOverflowFlag,
    input wire logic overflowClear,
    output logic portInterruptFlag,
    input wire logic interruptClear,
    output logic startSeen,
    output logic stopSeen,
    input wire logic serialIn,
    input wire logic slaveSelectN,
    output logic serialOutMaster,
    output logic serialOutSlave,
    output logic slaveOutSelect,
    output logic spiClkOut,
    output logic spiClkOe,
    output logic sdaOut,
    output logic sdaOe
);
    logic [3:0] mode;
    logic enable;
    logic isMaster;
    logic isSlave;
    logic isI2c;
    logic i2cSlave;
    logic i2cTen;
    logic i2cInts;
    logic [7:0] fifoData;
    logic fifoValid;
    logic fifoPop;
    logic [7:0] txByte_q;
    logic txHave_q;
    logic txTake;
    logic newByte;
    logic [7:0] newVal;
    logic blocked;

    assign mode = portControl[3:0];
    assign enable = portControl[ssb_pkg::CTRL_EN_BIT];
    assign isMaster = enable && (mode <= ssb_pkg::MODE_MST_SLOW);
    assign isSlave = enable && (mode == ssb_pkg::MODE_SLV_SS || mode == ssb_pkg::MODE_SLV_NOSS);
    assign i2cTen = (mode == ssb_pkg::MODE_I2C_10 || mode == ssb_pkg::MODE_I2C_10_INT);
    assign i2cSlave = enable && (i2cTen || mode == ssb_pkg::MODE_I2C_7
                                 || mode == ssb_pkg::MODE_I2C_7_INT);
    assign i2cInts = (mode == ssb_pkg::MODE_I2C_7_INT || mode == ssb_pkg::MODE_I2C_10_INT
                      || mode == ssb_pkg::MODE_I2C_IDLE_INT);
    assign isI2c = enable && (i2cSlave || i2cInts);
    // no ack or load while full or overflowed
    assign blocked = bufferFullFlag || receiveOverflowFlag;

    ssb_fifo #(
        .WIDTH(ssb_pkg::FIFO_WIDTH),
        .DEPTH(ssb_pkg::FIFO_DEPTH)
    ) txFifo (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(writeValid),
        .inReady(writeReady),
        .inData(writeData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link hold
    logic [1:0] ssMeta_q;
    logic [1:0] sdiMeta_q;
    logic [1:0] sclMeta_q;
    logic sdaPrev_q;
    logic sclPrev_q;
    logic linkHold_q;

    always_ff @(posedge clk) begin
        ssMeta_q <= {ssMeta_q[0], slaveSelectN};
        sdiMeta_q <= {sdiMeta_q[0], serialIn};
        sclMeta_q <= {sclMeta_q[0], serialClk};
        sdaPrev_q <= sdiMeta_q[1];
        sclPrev_q <= sclMeta_q[1];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            linkHold_q <= 1'b1;
        end else begin
            linkHold_q <= !isSlave || (mode == ssb_pkg::MODE_SLV_SS && ssMeta_q[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: SPI slave shifter
    logic [1:0] lRstMeta_q;
    logic [2:0] lCnt_q;
    logic [6:0] lShift_q;
    logic [7:0] lRxWord_q;
    logic lDoneTgl_q;
    logic [7:0] lTx_q;

    always_ff @(posedge serialClk) begin
        lRstMeta_q <= {lRstMeta_q[0], linkHold_q};
    end

    always_ff @(posedge serialClk) begin
        if (lRstMeta_q[1]) begin
            lCnt_q <= '0;
            lShift_q <= '0;
            lDoneTgl_q <= 1'b0;
            lRxWord_q <= ssb_pkg::BYTE_RESET;
        end else begin
            lCnt_q <= lCnt_q + 3'h1;
            lShift_q <= {lShift_q[5:0], serialIn};
            if (lCnt_q == 3'h7) begin
                lRxWord_q <= {lShift_q, serialIn};
                lDoneTgl_q <= !lDoneTgl_q;
            end
        end
    end

    // Reload between bytes; txByte_q holds while shifting
    always_ff @(negedge serialClk) begin
        if (lRstMeta_q[1] || lCnt_q == 3'h0) begin
            lTx_q <= txByte_q;
        end else begin
            lTx_q <= {lTx_q[6:0], 1'b0};
        end
    end
    assign serialOutSlave = lTx_q[7];

    logic [2:0] tglSync_q;
    logic slaveDone;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tglSync_q <= '0;
        end else begin
            tglSync_q <= {tglSync_q[1:0], lDoneTgl_q};
        end
    end
    assign slaveDone = isSlave && (tglSync_q[2] != tglSync_q[1]);

    ////////////////////////////////////////////////////////////////////////////
    // SPI master
    logic mBusy_q;
    logic [6:0] mDiv_q;
    logic [4:0] mHalf_q;
    logic [7:0] mShift_q;
    logic [7:0] mRx_q;
    logic mDone;
    logic [6:0] halfLen;
    logic cke;
    logic ckp;
    logic mStart;

    assign cke = portStatusCfg[ssb_pkg::STAT_CKE_BIT];
    assign ckp = portControl[ssb_pkg::CTRL_CKP_BIT];
    assign mStart = isMaster && !mBusy_q && fifoValid;
    assign mDone = mBusy_q && mDiv_q == 7'h01 && mHalf_q == ssb_pkg::HALF_PHASES - 5'h1;

    always_comb begin
        case (mode[1:0])
            2'b00: halfLen = ssb_pkg::HALF_DIV4;
            2'b01: halfLen = ssb_pkg::HALF_DIV16;
            2'b10: halfLen = ssb_pkg::HALF_DIV64;
            default: halfLen = ssb_pkg::HALF_SLOW;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n || !isMaster) begin
            mBusy_q <= 1'b0;
            mDiv_q <= '0;
            mHalf_q <= '0;
            mShift_q <= ssb_pkg::BYTE_RESET;
            mRx_q <= ssb_pkg::BYTE_RESET;
            spiClkOut <= 1'b0;
            spiClkOe <= 1'b0;
            serialOutMaster <= 1'b0;
        end else begin
            spiClkOe <= 1'b1;
            if (mStart) begin
                mBusy_q <= 1'b1;
                mDiv_q <= halfLen;
                mHalf_q <= '0;
                spiClkOut <= ckp;
                serialOutMaster <= cke ? serialOutMaster : fifoData[7];
                mShift_q <= cke ? fifoData : {fifoData[6:0], 1'b0};
            end else if (mBusy_q && mDiv_q == 7'h01) begin
                mDiv_q <= halfLen;
                mHalf_q <= mHalf_q + 5'h1;
                spiClkOut <= !spiClkOut;
                if (mHalf_q[0]) begin
                    mRx_q <= {mRx_q[6:0], sdiMeta_q[1]};
                end
                if (mHalf_q[0] != cke && !(mHalf_q == ssb_pkg::HALF_PHASES - 5'h1 && !cke)) begin
                    serialOutMaster <= mShift_q[7];
                    mShift_q <= {mShift_q[6:0], 1'b0};
                end
                if (mDone) begin
                    mBusy_q <= 1'b0;
                end
            end else if (mBusy_q) begin
                mDiv_q <= mDiv_q - 7'h01;
            end else begin
                spiClkOut <= ckp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I2C slave on the synchronised pins
    ssb_pkg::ssb_i2c_state_e iState_q;
    ssb_pkg::ssb_i2c_state_e iNext_q;
    logic [3:0] iCnt_q;
    logic [7:0] iShift_q;
    logic iTenHi_q;
    logic sclRise;
    logic sclFall;
    logic startEvt;
    logic stopEvt;
    logic iMatch;
    logic iRead;
    logic iByteEnd;
    logic iLoad;

    assign sclRise = sclMeta_q[1] && !sclPrev_q;
    assign sclFall = !sclMeta_q[1] && sclPrev_q;
    assign startEvt = isI2c && sclMeta_q[1] && sclPrev_q && sdaPrev_q && !sdiMeta_q[1];
    assign stopEvt = isI2c && sclMeta_q[1] && sclPrev_q && !sdaPrev_q && sdiMeta_q[1];
    assign iRead = iShift_q[0];
    assign iByteEnd = sclFall && iCnt_q == ssb_pkg::BYTE_BITS;

    always_comb begin
        iMatch = 1'b0;
        if (iState_q == ssb_pkg::I2C_RX) begin
            iMatch = 1'b1;
        end else if (iState_q == ssb_pkg::I2C_ADDR2) begin
            iMatch = (iShift_q == ownAddress[7:0]);
        end else if (i2cTen) begin
            iMatch = iShift_q[7:3] == ssb_pkg::TEN_BIT_HEAD && iShift_q[2:1] == ownAddress[9:8]
                     && (!iRead || iTenHi_q);
        end else begin
            iMatch = (iShift_q[7:1] == ownAddress[6:0]);
        end
    end
    assign iLoad = iByteEnd && iMatch && iState_q != ssb_pkg::I2C_IDLE
                   && iState_q != ssb_pkg::I2C_ACK && iState_q < ssb_pkg::I2C_TX;

    always_ff @(posedge clk) begin
        if (!reset_n || !i2cSlave) begin
            iState_q <= ssb_pkg::I2C_IDLE;
            iNext_q <= ssb_pkg::I2C_IDLE;
            iCnt_q <= '0;
            iShift_q <= ssb_pkg::BYTE_RESET;
            iTenHi_q <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopEvt) begin
            iState_q <= ssb_pkg::I2C_IDLE;
            iTenHi_q <= 1'b0;
            sdaOe <= 1'b0;
        end else if (startEvt) begin
            iState_q <= ssb_pkg::I2C_ADDR;
            iCnt_q <= '0;
            sdaOe <= 1'b0;
        end else if (sclRise) begin
            iShift_q <= {iShift_q[6:0], sdiMeta_q[1]};
            iCnt_q <= iCnt_q + 4'h1;
            if (iState_q == ssb_pkg::I2C_MACK) begin
                iState_q <= sdiMeta_q[1] ? ssb_pkg::I2C_IDLE : ssb_pkg::I2C_ACK;
                iNext_q <= ssb_pkg::I2C_TX;
            end
        end else if (iByteEnd && iState_q != ssb_pkg::I2C_TX) begin
            iCnt_q <= '0;
            if (iLoad && !blocked) begin
                // drive ack low when pin is an input
                sdaOe <= pinDirInput[1];
                iState_q <= ssb_pkg::I2C_ACK;
                if (iState_q == ssb_pkg::I2C_ADDR && i2cTen && !iRead) begin
                    iNext_q <= ssb_pkg::I2C_ADDR2;
                end else begin
                    iNext_q <= (iState_q == ssb_pkg::I2C_ADDR && iRead) ? ssb_pkg::I2C_TX
                                                                        : ssb_pkg::I2C_RX;
                end
                iTenHi_q <= iTenHi_q || iState_q == ssb_pkg::I2C_ADDR2;
            end else begin
                iState_q <= ssb_pkg::I2C_IDLE;
            end
        end else if (sclFall && iState_q == ssb_pkg::I2C_ACK) begin
            iState_q <= iNext_q;
            iCnt_q <= (iNext_q == ssb_pkg::I2C_TX) ? 4'h1 : 4'h0;
            sdaOe <= (iNext_q == ssb_pkg::I2C_TX) && !txByte_q[7] && pinDirInput[1];
            iShift_q <= {txByte_q[6:0], 1'b0};
        end else if (sclFall && iState_q == ssb_pkg::I2C_TX) begin
            if (iCnt_q == ssb_pkg::BYTE_BITS) begin
                sdaOe <= 1'b0;
                iState_q <= ssb_pkg::I2C_MACK;
            end else begin
                sdaOe <= !iShift_q[7] && pinDirInput[1];
                iShift_q <= {iShift_q[6:0], 1'b0};
                iCnt_q <= iCnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
        slaveOutSelect <= isSlave;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit preload for slave and I2C
    assign txTake = slaveDone || (sclFall && iState_q == ssb_pkg::I2C_ACK
                                  && iNext_q == ssb_pkg::I2C_TX && i2cSlave);
    assign fifoPop = mStart || (!isMaster && !txHave_q && fifoValid);

    always_ff @(posedge clk) begin
        if (!reset_n || !enable) begin
            txHave_q <= 1'b0;
            txByte_q <= ssb_pkg::BYTE_RESET;
        end else if (fifoPop && !isMaster) begin
            txHave_q <= 1'b1;
            txByte_q <= fifoData;
        end else if (txTake) begin
            txHave_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer and flags; a set wins over a same-cycle clear
    assign newByte = mDone || slaveDone || iLoad;
    assign newVal = mDone ? {mRx_q[6:0], sdiMeta_q[1]} : (slaveDone ? lRxWord_q : iShift_q);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            transferBuffer <= ssb_pkg::BYTE_RESET;
            bufferFullFlag <= 1'b0;
            receiveOverflowFlag <= 1'b0;
            portInterruptFlag <= 1'b0;
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
        end else begin
            if (newByte && !blocked) begin
                transferBuffer <= newVal;
                bufferFullFlag <= 1'b1;
            end else if (bufferRead) begin
                bufferFullFlag <= 1'b0;
            end
            if (newByte && bufferFullFlag) begin
                receiveOverflowFlag <= 1'b1;
            end else if (overflowClear) begin
                receiveOverflowFlag <= 1'b0;
            end
            if (newByte || ((startEvt || stopEvt) && i2cInts)
                || (sclRise && iState_q == ssb_pkg::I2C_MACK && i2cSlave)) begin
                portInterruptFlag <= 1'b1;
            end else if (interruptClear) begin
                portInterruptFlag <= 1'b0;
            end
            if (startEvt) begin
                startSeen <= 1'b1;
            end else if (stopEvt || !isI2c) begin
                startSeen <= 1'b0;
            end
            if (stopEvt) begin
                stopSeen <= 1'b1;
            end else if (startEvt || !isI2c) begin
                stopSeen <= 1'b0;
            end
        end
    end
endmodule : ssb_port

// ### ssb_pkg.sv
package ssb_pkg;
    // Control word fields
    localparam int CTRL_OVF_BIT = 6;
    localparam int CTRL_EN_BIT = 5;
    localparam int CTRL_CKP_BIT = 4;
    // Status configuration pair: bit 1 = sample phase, bit 0 = clock edge
    localparam int STAT_CKE_BIT = 0;
    // Mode field encodings
    localparam logic [3:0] MODE_MST_DIV4 = 4'h0;
    localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MST_SLOW = 4'h3;
    localparam logic [3:0] MODE_SLV_SS = 4'h4;
    localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
    localparam logic [3:0] MODE_I2C_7 = 4'h6;
    localparam logic [3:0] MODE_I2C_10 = 4'h7;
    localparam logic [3:0] MODE_I2C_IDLE_INT = 4'hb;
    localparam logic [3:0] MODE_I2C_7_INT = 4'he;
    localparam logic [3:0] MODE_I2C_10_INT = 4'hf;
    // Master half period of the serial clock, in system clocks
    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_SLOW = 7'h40;
    localparam logic [4:0] HALF_PHASES = 5'h10;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] TEN_BIT_HEAD = 5'h1e;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_ADDR2 = 3'b010,
        I2C_ACK = 3'b011,
        I2C_RX = 3'b100,
        I2C_TX = 3'b101,
        I2C_MACK = 3'b110
    } ssb_i2c_state_e;
endpackage : ssb_pkg

// ### ssb_port_checker.sv
`timescale 1ns/10ps

module ssb_port_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] portControl,
    input wire logic [1:0] pinDirInput,
    input wire logic bufferRead,
    input wire logic [7:0] transferBuffer,
    input wire logic bufferFullFlag,
    input wire logic receiveOverflowFlag,
    input wire logic overflowClear,
    input wire logic portInterruptFlag,
    input wire logic interruptClear,
    input wire logic spiClkOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_full_set;
        !bufferFullFlag ##1 bufferFullFlag;
    endsequence
    sequence s_ovf_set;
        !receiveOverflowFlag ##1 receiveOverflowFlag;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_full_sets_int: assert property (s_full_set |-> portInterruptFlag)
        else $error("no interrupt on fill");
    a_ovf_needs_full: assert property (s_ovf_set |-> $past(bufferFullFlag))
        else $error("overflow without full");
    a_read_clears_full: assert property (bufferRead |=> !bufferFullFlag)
        else $error("read kept full");
    a_ovf_sticky: assert property (receiveOverflowFlag && !overflowClear |=> receiveOverflowFlag)
        else $error("overflow dropped");
    a_buffer_frozen: assert property ((bufferFullFlag && !bufferRead) ||
        (receiveOverflowFlag && !overflowClear) |=> $stable(transferBuffer))
        else $error("buffer changed while held");
    a_int_sticky: assert property (portInterruptFlag && !interruptClear |=> portInterruptFlag)
        else $error("interrupt dropped");
    a_master_clk_only: assert property ((!portControl[5] || portControl[3:2] != 2'b00)[*2]
        |-> !spiClkOe)
        else $error("clock driven outside master");
    a_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
    a_sda_needs_cfg: assert property ((!pinDirInput[1] || !portControl[5])[*2] |-> !sdaOe)
        else $error("data pulled while barred");
endmodule : ssb_port_checker

bind ssb_port ssb_port_checker i_ssb_port_checker (
    .clk(clk), .reset_n(reset_n), .portControl(portControl), .pinDirInput(pinDirInput),
    .bufferRead(bufferRead), .transferBuffer(transferBuffer), .bufferFullFlag(bufferFullFlag),
    .receiveOverflowFlag(receiveOverflowFlag), .overflowClear(overflowClear),
    .portInterruptFlag(portInterruptFlag), .interruptClear(interruptClear),
    .spiClkOe(spiClkOe), .sdaOut(sdaOut), .sdaOe(sdaOe)
);

// ### ssb_spi_partner.sv
`timescale 1ns/10ps

module ssb_spi_partner (
    input wire logic sckIn,
    input wire logic polarity,
    input wire logic mosi,
    output logic miso,
    output logic linkClk,
    output logic [7:0] rxByte
);
    logic [7:0] shift_q;
    logic lead;

    assign lead = sckIn ^ polarity;
    assign miso = shift_q[7];
    initial {shift_q, linkClk, rxByte} = 17'h00000;
    ////////////////////////////////////////////////////////////////////////////
    // capture on leading edge
    always @(posedge lead) begin
        rxByte <= {rxByte[6:0], mosi};
    end
    // shift on trailing edge, refill inverted
    always @(negedge lead) begin
        shift_q <= {shift_q[6:0], ~shift_q[7]};
    end
    task preload(input logic [7:0] b);
        shift_q = b;
    endtask : preload
    task send(input logic [7:0] b, input int nBits);
        shift_q = b;
        for (int i = 0; i < nBits; i++) begin
            #15 linkClk = 1'b1;
            #15 linkClk = 1'b0;
            shift_q = {shift_q[6:0], ~shift_q[7]};
        end
    endtask : send
endmodule : ssb_spi_partner

// ### ssb_port_test.sv
`timescale 1ns/10ps

module ssb_port_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] portControl = 8'h00;
    logic [1:0] portStatusCfg = 2'h0;
    logic [9:0] ownAddress = 10'h02a;
    logic [1:0] pinDirInput = 2'h2;
    logic [7:0] writeData = 8'h00;
    logic writeValid = 1'b0;
    logic bufferRead = 1'b0;
    logic overflowClear = 1'b0;
    logic interruptClear = 1'b0;
    logic slaveSelectN = 1'b1;
    logic useI2c = 1'b0;
    logic sclTb = 1'b1;
    logic sdaTb = 1'b1;
    logic writeReady, bufferFullFlag, receiveOverflowFlag, portInterruptFlag, startSeen, stopSeen;
    logic serialOutMaster, serialOutSlave, slaveOutSelect, spiClkOut, spiClkOe, sdaOut, sdaOe;
    logic pClk, pSdi;
    logic [7:0] transferBuffer, rxByte;
    wire logic serialClk;
    wire logic serialIn;
    int err_total = 0;
    int n_checks = 0;

    always #50 clk = ~clk;
    assign serialClk = useI2c ? sclTb : pClk;
    assign serialIn = useI2c ? (sdaTb & ~sdaOe) : pSdi;

    ssb_port i_ssb_port (
        .clk(clk), .reset_n(reset_n), .serialClk(serialClk), .portControl(portControl),
        .portStatusCfg(portStatusCfg), .ownAddress(ownAddress), .pinDirInput(pinDirInput),
        .writeData(writeData), .writeValid(writeValid), .writeReady(writeReady),
        .bufferRead(bufferRead), .transferBuffer(transferBuffer),
        .bufferFullFlag(bufferFullFlag), .receiveOverflowFlag(receiveOverflowFlag),
        .overflowClear(overflowClear), .portInterruptFlag(portInterruptFlag),
        .interruptClear(interruptClear), .startSeen(startSeen), .stopSeen(stopSeen),
        .serialIn(serialIn), .slaveSelectN(slaveSelectN), .serialOutMaster(serialOutMaster),
        .serialOutSlave(serialOutSlave), .slaveOutSelect(slaveOutSelect),
        .spiClkOut(spiClkOut), .spiClkOe(spiClkOe), .sdaOut(sdaOut), .sdaOe(sdaOe)
    );
    ssb_spi_partner i_ssb_spi_partner (
        .sckIn(spiClkOut), .polarity(portControl[4]), .mosi(serialOutMaster), .miso(pSdi),
        .linkClk(pClk), .rxByte(rxByte)
    );
    ////////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task config_port(input logic [7:0] ctrl);
        portControl = ctrl & 8'hdf;
        tick(2);
        portControl = ctrl;
        tick(2);
    endtask : config_port
    task strobe(input logic rd, input logic ov, input logic ic);
        {bufferRead, overflowClear, interruptClear} = {rd, ov, ic};
        tick(1);
        {bufferRead, overflowClear, interruptClear} = 3'h0;
    endtask : strobe
    task write_byte(input logic [7:0] b);
        check("writeReady", 8'h01, writeReady);
        writeData = b;
        writeValid = 1'b1;
        tick(1);
        writeValid = 1'b0;
    endtask : write_byte
    task wait_full(output int cnt);
        cnt = 0;
        while (bufferFullFlag !== 1'b1 && cnt < 2000) begin
            tick(1);
            cnt++;
        end
        if (cnt >= 2000) begin
            check("bufferFullFlag", 8'h01, bufferFullFlag);
            tally_and_finish();
        end
    endtask : wait_full
    task i2c_bit(input logic b);
        sclTb = 1'b0;
        tick(2);
        sdaTb = b;
        tick(2);
        sclTb = 1'b1;
        tick(4);
    endtask : i2c_bit
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int cnt;
        int half;
        tick(1);
        i_ssb_spi_partner.send(8'h00, 4);
        tick(1);
        reset_n = 1'b1;
        tick(2);
        check("bufferFullFlag", 8'h00, bufferFullFlag);
        check("transferBuffer", 8'h00, transferBuffer);
        check("portInterruptFlag", 8'h00, portInterruptFlag);
        for (int m = 0; m < 4; m++) begin
            half = (m == 0) ? ssb_pkg::HALF_DIV4 : (m == 1) ? ssb_pkg::HALF_DIV16 :
                (m == 2) ? ssb_pkg::HALF_DIV64 : ssb_pkg::HALF_SLOW;
            config_port({3'b001, m[0], m[3:0]});
            i_ssb_spi_partner.preload(8'h3c ^ 8'(m));
            write_byte(8'ha5 ^ 8'(m));
            wait_full(cnt);
            check("masterTime", 8'h01, 8'(cnt >= 16 * half - 2 && cnt <= 16 * half + 4));
            check("transferBuffer", 8'h3c ^ 8'(m), transferBuffer);
            check("partnerRx", 8'ha5 ^ 8'(m), rxByte);
            check("portInterruptFlag", 8'h01, portInterruptFlag);
            check("spiClkOe", 8'h01, spiClkOe);
            check("spiClkOut", 8'(m & 1), spiClkOut);
            strobe(1'b1, 1'b0, 1'b1);
        end
        config_port(8'h20);
        i_ssb_spi_partner.preload(8'h55);
        write_byte(8'h11);
        wait_full(cnt);
        i_ssb_spi_partner.preload(8'h0f);
        write_byte(8'hc3);
        tick(40);
        check("receiveOverflowFlag", 8'h01, receiveOverflowFlag);
        check("transferBuffer", 8'h55, transferBuffer);
        strobe(1'b1, 1'b0, 1'b1);
        check("bufferFullFlag", 8'h00, bufferFullFlag);
        check("receiveOverflowFlag", 8'h01, receiveOverflowFlag);
        i_ssb_spi_partner.preload(8'h66);
        write_byte(8'h22);
        tick(40);
        check("transferBuffer", 8'h55, transferBuffer);
        check("portInterruptFlag", 8'h01, portInterruptFlag);
        strobe(1'b0, 1'b1, 1'b1);
        check("receiveOverflowFlag", 8'h00, receiveOverflowFlag);
        portControl = 8'h00;
        tick(2);
        write_byte(8'h77);
        tick(40);
        check("bufferFullFlag", 8'h00, bufferFullFlag);
        pinDirInput = 2'h3;
        config_port(8'h25);
        i_ssb_spi_partner.send(8'h00, 2);
        i_ssb_spi_partner.send(8'h96, 8);
        wait_full(cnt);
        check("transferBuffer", 8'h96, transferBuffer);
        check("spiClkOe", 8'h00, spiClkOe);
        check("slaveOutSelect", 8'h01, slaveOutSelect);
        strobe(1'b1, 1'b0, 1'b1);
        config_port(8'h24);
        slaveSelectN = 1'b0;
        tick(4);
        i_ssb_spi_partner.send(8'hf0, 4);
        tick(2);
        slaveSelectN = 1'b1;
        tick(4);
        i_ssb_spi_partner.send(8'h00, 2);
        slaveSelectN = 1'b0;
        tick(4);
        i_ssb_spi_partner.send(8'h00, 2);
        i_ssb_spi_partner.send(8'h4b, 8);
        wait_full(cnt);
        check("transferBuffer", 8'h4b, transferBuffer);
        strobe(1'b1, 1'b0, 1'b1);
        useI2c = 1'b1;
        config_port(8'h26);
        sdaTb = 1'b0;
        tick(4);
        check("startSeen", 8'h01, startSeen);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'(8'h54 >> i));
        end
        sclTb = 1'b0;
        tick(2);
        sdaTb = 1'b1;
        tick(2);
        check("sdaOe", 8'h01, sdaOe);
        sclTb = 1'b1;
        tick(4);
        check("sdaLine", 8'h00, serialIn);
        sclTb = 1'b0;
        tick(6);
        check("sdaOe", 8'h00, sdaOe);
        check("transferBuffer", 8'h54, transferBuffer);
        check("bufferFullFlag", 8'h01, bufferFullFlag);
        sdaTb = 1'b0;
        tick(2);
        sclTb = 1'b1;
        tick(2);
        sdaTb = 1'b1;
        tick(4);
        check("stopSeen", 8'h01, stopSeen);
        tally_and_finish();
    end
endmodule : ssb_port_test
